// ==== rdr_eq_term_ctrl.sv ====
// equaliser, termination and signal detect control of the redriver
// Summary of operation
// - strap pair, high first, selects receive gain
// - each strap reads low, floating or high
// - global register code drives every data lane
// - independent mode uses per-lane nibbles from pairs
// - clock lane gain from global two-bit field
// - no valid clock with detection on: standby
// - standby makes outputs and data inputs high-impedance
// - signal detection is enabled out of reset
// - status bit five shows valid clock detected
// - register field selects termination; the automatic code gives none
// - termination strap low, floating, high selects termination
// - clock ratio flag set forces 75-150 ohm
// - snooped ratio write updates the ratio flag
module rdr_eq_term_ctrl (
   input wire logic clk,
   input wire logic nrst, // output-enable pin, low resets every register, strap level and output
   input wire logic reg_ctrl_en, // high selects register control
   input wire rdr_pkg::rdr_strap_pin_t equalizer_strap_low, // also address_strap_low
   input wire rdr_pkg::rdr_strap_pin_t equalizer_strap_high, // also address_strap_high
   input wire rdr_pkg::rdr_strap_pin_t term_strap,
   input wire logic clock_valid, // analog clock detector
   input wire logic host_scl,
   input wire logic host_sda_in,
   output logic host_sda_out,
   output logic host_sda_oe_n,
   input wire logic ddc_scl,
   input wire logic ddc_sda_in,
   output rdr_pkg::rdr_lane_eq_t receive_gain,
   output logic [1:0] term_sel,
   output logic standby,
   output logic hs_out_hiz,
   output logic data_in_hiz
);
   // software-visible registers
   logic [7:0] lane_mode_control;
   logic [7:0] signal_detect_control;
   logic [7:0] termination_and_ratio_control;
   logic [7:0] global_equalizer_control;
   logic [7:0] lane_equalizer_pair_a;
   logic [7:0] lane_equalizer_pair_b;
   // captured strap levels
   rdr_pkg::rdr_lvl_t lvl_eq_low, lvl_eq_high, lvl_term;
   logic strap_taken; // straps caught once after reset release
   logic clk_det; // registered detector, the status source
   logic [7:0] rd_data;
   logic [7:0] host_off;
   logic host_oe_n;
   rdr_pkg::rdr_wr_t host_wr, snoop_wr;
   rdr_pkg::rdr_lane_eq_t next_gain;
   logic [3:0] strap_eq;
   logic [1:0] next_term;

   // three-level sense to level
   function automatic rdr_pkg::rdr_lvl_t lvl_of(input rdr_pkg::rdr_strap_pin_t p);
      if (p.floating) begin
         lvl_of = rdr_pkg::RDR_LVL_FLOAT;
      end else if (p.pulled_high) begin
         lvl_of = rdr_pkg::RDR_LVL_HIGH;
      end else begin
         lvl_of = rdr_pkg::RDR_LVL_LOW;
      end
   endfunction

   // straps are caught on the first edge after release, never under the async reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         strap_taken <= 1'b0;
         lvl_eq_low <= rdr_pkg::RDR_LVL_LOW;
         lvl_eq_high <= rdr_pkg::RDR_LVL_LOW;
         lvl_term <= rdr_pkg::RDR_LVL_LOW;
      end else if (!strap_taken) begin
         strap_taken <= 1'b1;
         lvl_eq_low <= lvl_of(equalizer_strap_low);
         lvl_eq_high <= lvl_of(equalizer_strap_high);
         lvl_term <= lvl_of(term_strap);
      end
   end

   // host address low bits from the shared straps; floating counts as zero
   wire [6:0] host_addr = rdr_pkg::RDR_HOST_ADDR_BASE |
      {5'h00, lvl_eq_high == rdr_pkg::RDR_LVL_HIGH, lvl_eq_low == rdr_pkg::RDR_LVL_HIGH};

   // host register port, answers reads and acknowledges
   rdr_i2c_target #(.RESPOND(1'b1)) u_host (
      .clk(clk),
      .nrst(nrst),
      .scl(host_scl),
      .sda_in(host_sda_in),
      .dev_addr(host_addr),
      .rd_data(rd_data),
      .cur_off(host_off),
      .wr(host_wr),
      .sda_oe_n(host_oe_n)
   );

   // display-channel listener; it never drives the line
   rdr_i2c_target #(.RESPOND(1'b0)) u_snoop (
      .clk(clk),
      .nrst(nrst),
      .scl(ddc_scl),
      .sda_in(ddc_sda_in),
      .dev_addr(rdr_pkg::RDR_SNOOP_ADDR),
      .rd_data(8'h00),
      .cur_off(),
      .wr(snoop_wr),
      .sda_oe_n()
   );

   // read decode; unmapped offsets read zero
   always_comb begin
      if (host_off == rdr_pkg::RDR_OFF_LANE_MODE) begin
         rd_data = lane_mode_control;
      end else if (host_off == rdr_pkg::RDR_OFF_SIG_DETECT_CTRL) begin
         rd_data = signal_detect_control;
      end else if (host_off == rdr_pkg::RDR_OFF_TERM) begin
         rd_data = termination_and_ratio_control;
      end else if (host_off == rdr_pkg::RDR_OFF_GEQ) begin
         rd_data = global_equalizer_control;
      end else if (host_off == rdr_pkg::RDR_OFF_STATUS) begin
         rd_data = 8'h00;
         rd_data[rdr_pkg::RDR_BIT_CLK_VALID] = clk_det;
      end else if (host_off == rdr_pkg::RDR_OFF_PAIR_A) begin
         rd_data = lane_equalizer_pair_a;
      end else if (host_off == rdr_pkg::RDR_OFF_PAIR_B) begin
         rd_data = lane_equalizer_pair_b;
      end else begin
         rd_data = 8'h00;
      end
   end

   // write decode strobes
   wire wr_lane = host_wr.stb && host_wr.off == rdr_pkg::RDR_OFF_LANE_MODE;
   wire wr_sig = host_wr.stb && host_wr.off == rdr_pkg::RDR_OFF_SIG_DETECT_CTRL;
   wire wr_term = host_wr.stb && host_wr.off == rdr_pkg::RDR_OFF_TERM;
   wire wr_geq = host_wr.stb && host_wr.off == rdr_pkg::RDR_OFF_GEQ;
   wire wr_pa = host_wr.stb && host_wr.off == rdr_pkg::RDR_OFF_PAIR_A;
   wire wr_pb = host_wr.stb && host_wr.off == rdr_pkg::RDR_OFF_PAIR_B;
   wire snoop_ratio = snoop_wr.stb && snoop_wr.off == rdr_pkg::RDR_SNOOP_OFF;

   // register file; reset (output enable low) clears all host programming
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lane_mode_control <= rdr_pkg::RDR_RST_LANE_MODE;
         signal_detect_control <= rdr_pkg::RDR_RST_SIG_DETECT_CTRL;
         termination_and_ratio_control <= rdr_pkg::RDR_RST_TERM;
         global_equalizer_control <= rdr_pkg::RDR_RST_GEQ;
         lane_equalizer_pair_a <= rdr_pkg::RDR_RST_PAIR;
         lane_equalizer_pair_b <= rdr_pkg::RDR_RST_PAIR;
      end else begin
         if (wr_lane) begin
            lane_mode_control <= host_wr.data;
         end
         if (wr_sig) begin
            signal_detect_control <= host_wr.data;
         end
         if (wr_term) begin
            termination_and_ratio_control <= host_wr.data;
         end
         // source write lands after the host one, so it wins a tie
         if (snoop_ratio) begin
            termination_and_ratio_control[rdr_pkg::RDR_BIT_RATIO] <= snoop_wr.data[1];
         end
         if (wr_geq) begin
            global_equalizer_control <= host_wr.data;
         end
         if (wr_pa) begin
            lane_equalizer_pair_a <= host_wr.data;
         end
         if (wr_pb) begin
            lane_equalizer_pair_b <= host_wr.data;
         end
      end
   end

   // strap pair decode, high strap first
   always_comb begin
      case ({lvl_eq_high, lvl_eq_low})
         {rdr_pkg::RDR_LVL_LOW, rdr_pkg::RDR_LVL_LOW}: strap_eq = rdr_pkg::RDR_EQ_00;
         {rdr_pkg::RDR_LVL_LOW, rdr_pkg::RDR_LVL_FLOAT}: strap_eq = rdr_pkg::RDR_EQ_0Z;
         {rdr_pkg::RDR_LVL_LOW, rdr_pkg::RDR_LVL_HIGH}: strap_eq = rdr_pkg::RDR_EQ_01;
         {rdr_pkg::RDR_LVL_FLOAT, rdr_pkg::RDR_LVL_LOW}: strap_eq = rdr_pkg::RDR_EQ_Z0;
         {rdr_pkg::RDR_LVL_FLOAT, rdr_pkg::RDR_LVL_FLOAT}: strap_eq = rdr_pkg::RDR_EQ_ZZ;
         {rdr_pkg::RDR_LVL_FLOAT, rdr_pkg::RDR_LVL_HIGH}: strap_eq = rdr_pkg::RDR_EQ_Z1;
         {rdr_pkg::RDR_LVL_HIGH, rdr_pkg::RDR_LVL_LOW}: strap_eq = rdr_pkg::RDR_EQ_10;
         {rdr_pkg::RDR_LVL_HIGH, rdr_pkg::RDR_LVL_FLOAT}: strap_eq = rdr_pkg::RDR_EQ_1Z;
         default: strap_eq = rdr_pkg::RDR_EQ_11;
      endcase
   end

   // register equaliser fields
   wire [3:0] geq = global_equalizer_control[rdr_pkg::RDR_BIT_GEQ_LO +: 4];
   wire [1:0] clk_field = global_equalizer_control[rdr_pkg::RDR_BIT_CLKEQ_LO +: 2];
   wire lane_mode = lane_mode_control[rdr_pkg::RDR_BIT_LANE_MODE];

   // gain source selection
   always_comb begin
      if (!reg_ctrl_en) begin
         next_gain = {4{strap_eq}};
      end else if (lane_mode) begin
         next_gain.d2 = lane_equalizer_pair_a[3:0];
         next_gain.d1 = lane_equalizer_pair_a[7:4];
         next_gain.d0 = lane_equalizer_pair_b[3:0];
         next_gain.clk_lane = {clk_field, 2'b00};
      end else begin
         next_gain.d2 = geq;
         next_gain.d1 = geq;
         next_gain.d0 = geq;
         next_gain.clk_lane = {clk_field, 2'b00};
      end
   end

   // termination selection; the ratio flag overrides every source
   wire ratio_flag = termination_and_ratio_control[rdr_pkg::RDR_BIT_RATIO];
   wire [1:0] term_field = termination_and_ratio_control[rdr_pkg::RDR_BIT_TERM_LO +: 2];
   always_comb begin
      if (ratio_flag) begin
         next_term = rdr_pkg::RDR_TERM_75_150;
      end else if (reg_ctrl_en) begin
         // automatic with the flag clear falls back to no termination
         next_term = (term_field == rdr_pkg::RDR_TERM_AUTO) ? rdr_pkg::RDR_TERM_NONE : term_field;
      end else if (lvl_term == rdr_pkg::RDR_LVL_HIGH) begin
         next_term = rdr_pkg::RDR_TERM_75_150;
      end else if (lvl_term == rdr_pkg::RDR_LVL_FLOAT) begin
         next_term = rdr_pkg::RDR_TERM_NONE;
      end else begin
         next_term = rdr_pkg::RDR_TERM_150_300;
      end
   end

   wire signal_detect_enable = signal_detect_control[rdr_pkg::RDR_BIT_SIGNAL_DETECT_ENABLE];
   wire next_standby = signal_detect_enable & ~clk_det;

   // output flops; standby needs two edges after the detector falls
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         clk_det <= 1'b0;
         receive_gain <= '0;
         term_sel <= rdr_pkg::RDR_TERM_150_300;
         standby <= 1'b1;
         hs_out_hiz <= 1'b1;
         data_in_hiz <= 1'b1;
         host_sda_out <= 1'b0;
         host_sda_oe_n <= 1'b1;
      end else begin
         clk_det <= clock_valid;
         receive_gain <= next_gain;
         term_sel <= next_term;
         standby <= next_standby;
         hs_out_hiz <= next_standby;
         data_in_hiz <= next_standby;
         host_sda_out <= 1'b0;
         host_sda_oe_n <= host_oe_n;
      end
   end

   // checks
   a_strap_eq_low: assert property (@(posedge clk) disable iff (!nrst)
      (!reg_ctrl_en && strap_taken && lvl_eq_high == rdr_pkg::RDR_LVL_LOW && lvl_eq_low == rdr_pkg::RDR_LVL_LOW)
      |=> receive_gain.d0 == 4'h0 && receive_gain.clk_lane == 4'h0)
      else $error("strap low pair did not give lowest gain");
   a_strap_eq_high: assert property (@(posedge clk) disable iff (!nrst)
      (!reg_ctrl_en && lvl_eq_high == rdr_pkg::RDR_LVL_HIGH && lvl_eq_low == rdr_pkg::RDR_LVL_HIGH)
      |=> receive_gain.d2 == 4'hF)
      else $error("strap high pair did not give highest gain");
   a_strap_float: assert property (@(posedge clk) disable iff (!nrst)
      (strap_taken && equalizer_strap_low.floating && equalizer_strap_high.floating && !reg_ctrl_en)
      ##1 (!reg_ctrl_en && $stable(lvl_eq_low)) |=> receive_gain.d1 == 4'h6)
      else $error("floating straps not decoded as middle level");
   a_global_eq: assert property (@(posedge clk) disable iff (!nrst)
      (reg_ctrl_en && !lane_mode) |=> receive_gain.d0 == $past(geq) && receive_gain.d1 == receive_gain.d2)
      else $error("global code not applied to data lanes");
   a_lane_eq: assert property (@(posedge clk) disable iff (!nrst)
      (reg_ctrl_en && lane_mode) |=> receive_gain.d1 == $past(lane_equalizer_pair_a[7:4])
      && receive_gain.d0 == $past(lane_equalizer_pair_b[3:0]))
      else $error("per-lane code not applied");
   a_clk_lane_eq: assert property (@(posedge clk) disable iff (!nrst)
      reg_ctrl_en |=> receive_gain.clk_lane[3:2] == $past(clk_field))
      else $error("clock lane gain not from two-bit field");
   sequence s_clock_lost;
      signal_detect_enable && !clock_valid ##1 signal_detect_enable && !clock_valid;
   endsequence
   a_standby_entry: assert property (@(posedge clk) disable iff (!nrst)
      s_clock_lost |=> standby && hs_out_hiz && data_in_hiz)
      else $error("no standby after clock loss");
   a_status_live: assert property (@(posedge clk) disable iff (!nrst)
      clock_valid [*2] |-> ##1 !standby && clk_det)
      else $error("valid clock not reflected");
   a_ratio_term: assert property (@(posedge clk) disable iff (!nrst)
      ratio_flag |=> term_sel == rdr_pkg::RDR_TERM_75_150)
      else $error("ratio flag did not force termination");
   a_snoop_flag: assert property (@(posedge clk) disable iff (!nrst)
      snoop_ratio |=> ratio_flag == $past(snoop_wr.data[1]) ##1 term_sel[0] == ($past(snoop_wr.data[1], 2) | term_sel[0]))
      else $error("snooped ratio write not copied");
   a_term_strap: assert property (@(posedge clk) disable iff (!nrst)
      (!reg_ctrl_en && !ratio_flag && lvl_term == rdr_pkg::RDR_LVL_FLOAT) |=> term_sel == rdr_pkg::RDR_TERM_NONE)
      else $error("floating termination strap not honoured");
endmodule // rdr_eq_term_ctrl

// ==== rdr_host_model.sv ====
// two-wire controller model with a pulled-up data line, used for host and snoop links
module rdr_host_model (
   input wire logic clk,
   input wire logic dev_oe_n,
   output logic scl,
   output wire logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   logic drv = 1'b1; // own data driver, 1 = released
   logic k; // ack seen on the last byte sent
   initial scl = 1'b1;
   // pull-up: the line is low only while someone pulls it
   assign sda = drv & dev_oe_n;
   // one line phase, four cycles long to meet the target's minimum
   task automatic hw(input logic s, input logic d);
      scl = s;
      drv = d;
      repeat (4) @(negedge clk);
   endtask
   // start from any state; scl falls first so a held ack is not read as a stop
   task automatic start();
      hw(1'b0, 1'b1);
      hw(1'b1, 1'b1);
      hw(1'b1, 1'b0);
   endtask
   task automatic stop();
      hw(1'b0, 1'b0);
      hw(1'b1, 1'b0);
      hw(1'b1, 1'b1);
   endtask
   // one byte, msb first, then release for the ack slot
   task automatic put(input logic [7:0] v);
      for (int i = 7; i >= 0; i--) begin
         hw(1'b0, v[i]);
         hw(1'b1, v[i]);
      end
      hw(1'b0, 1'b1);
      hw(1'b1, 1'b1);
      k = ~sda;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d);
      start();
      put({a, 1'b0});
      put(o);
      put(d);
      stop();
   endtask
   // offset write, repeated start, one byte read, then nack and stop
   task automatic rd(input logic [6:0] a, input logic [7:0] o, output logic [7:0] d);
      start();
      put({a, 1'b0});
      put(o);
      start();
      put({a, 1'b1});
      for (int i = 7; i >= 0; i--) begin
         hw(1'b0, 1'b1);
         hw(1'b1, 1'b1);
         d[i] = sda;
      end
      hw(1'b0, 1'b1);
      hw(1'b1, 1'b1);
      stop();
   endtask
endmodule // rdr_host_model

// ==== rdr_i2c_target.sv ====
// two-wire register target, either answering or silently listening
module rdr_i2c_target #(
   parameter bit RESPOND = 1'b1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl,
   input wire logic sda_in,
   input wire logic [6:0] dev_addr,
   input wire logic [7:0] rd_data,
   output logic [7:0] cur_off,
   output rdr_pkg::rdr_wr_t wr,
   output logic sda_oe_n
);
   rdr_pkg::rdr_i2c_st_t st; // transfer phase
   logic scl_q; // previous clock level
   logic sda_q; // previous data level
   logic [3:0] slot; // bit slot, 8 is the acknowledge
   logic [6:0] shreg; // bits received so far
   logic [7:0] tx; // byte being returned
   logic ack_due; // acknowledge owed in slot 8

   // edge and condition decode; inputs are already clock-synchronous
   wire scl_rise = scl & ~scl_q;
   wire scl_fall = ~scl & scl_q;
   wire start_c = scl & scl_q & sda_q & ~sda_in;
   wire stop_c = scl & scl_q & ~sda_q & sda_in;
   wire [7:0] rx_byte = {shreg, sda_in};
   wire [3:0] next_slot = (slot == rdr_pkg::RDR_ACK_SLOT) ? 4'h0 : slot + 4'h1;
   wire addr_hit = (rx_byte[7:1] == dev_addr);

   // byte engine
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st <= rdr_pkg::RDR_ST_IDLE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         slot <= 4'h0;
         shreg <= 7'h00;
         tx <= 8'h00;
         ack_due <= 1'b0;
         cur_off <= 8'h00;
         wr <= '0;
         sda_oe_n <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda_in;
         wr.stb <= 1'b0;
         if (start_c) begin
            // start or repeated start: next byte is an address
            st <= rdr_pkg::RDR_ST_ADDR;
            // parked on the ack slot so the first clock fall opens bit slot 0
            slot <= rdr_pkg::RDR_ACK_SLOT;
            ack_due <= 1'b0;
            sda_oe_n <= 1'b1;
         end else if (stop_c) begin
            st <= rdr_pkg::RDR_ST_IDLE;
            ack_due <= 1'b0;
            sda_oe_n <= 1'b1;
         end else if (scl_rise && st != rdr_pkg::RDR_ST_IDLE) begin
            if (slot == 4'h7) begin
               // a whole byte has arrived
               case (st)
                  rdr_pkg::RDR_ST_ADDR: begin
                     ack_due <= addr_hit;
                     if (!addr_hit) begin
                        st <= rdr_pkg::RDR_ST_IDLE;
                     end else if (rx_byte[0]) begin
                        st <= rdr_pkg::RDR_ST_RDAT;
                     end else begin
                        st <= rdr_pkg::RDR_ST_OFFS;
                     end
                  end
                  rdr_pkg::RDR_ST_OFFS: begin
                     cur_off <= rx_byte;
                     ack_due <= 1'b1;
                     st <= rdr_pkg::RDR_ST_WDAT;
                  end
                  rdr_pkg::RDR_ST_WDAT: begin
                     // write uses the current offset, then steps on
                     wr.stb <= 1'b1;
                     wr.off <= cur_off;
                     wr.data <= rx_byte;
                     cur_off <= cur_off + 8'h01;
                     ack_due <= 1'b1;
                  end
                  default: begin
                     ack_due <= 1'b0;
                  end
               endcase
            end else if (slot == rdr_pkg::RDR_ACK_SLOT && st == rdr_pkg::RDR_ST_RDAT && !ack_due) begin
               // controller nack ends a read, ack moves on; the address ack slot is our own
               if (sda_in) begin
                  st <= rdr_pkg::RDR_ST_IDLE;
               end else begin
                  cur_off <= cur_off + 8'h01;
               end
            end else begin
               shreg <= rx_byte[6:0];
            end
         end else if (scl_fall && st != rdr_pkg::RDR_ST_IDLE) begin
            // data changes only while the clock is low
            slot <= next_slot;
            if (next_slot == rdr_pkg::RDR_ACK_SLOT) begin
               sda_oe_n <= ~(ack_due & RESPOND);
            end else if (st == rdr_pkg::RDR_ST_RDAT) begin
               if (next_slot == 4'h0) begin
                  tx <= rd_data;
                  sda_oe_n <= rd_data[7] | ~RESPOND;
               end else begin
                  sda_oe_n <= tx[7 - next_slot[2:0]] | ~RESPOND;
               end
            end else begin
               sda_oe_n <= 1'b1;
            end
            if (next_slot == 4'h0) begin
               ack_due <= 1'b0;
            end
         end
      end
   end
endmodule // rdr_i2c_target

// ==== rdr_pkg.sv ====
// shared constants, types and register map of the redriver control block
package rdr_pkg;
   // strap pin as seen by its three-level sense comparators
   typedef struct packed {
      logic pulled_high; // 1 when a pull-up is fitted
      logic floating; // 1 when nothing is fitted
   } rdr_strap_pin_t;

   // decoded strap level
   typedef enum logic [1:0] {
      RDR_LVL_LOW = 2'h0,
      RDR_LVL_FLOAT = 2'h1,
      RDR_LVL_HIGH = 2'h2
   } rdr_lvl_t;

   // equaliser code of every lane, named by unswapped pins
   typedef struct packed {
      logic [3:0] clk_lane;
      logic [3:0] d2;
      logic [3:0] d1;
      logic [3:0] d0;
   } rdr_lane_eq_t;

   // one register write seen on a two-wire link
   typedef struct packed {
      logic stb;
      logic [7:0] off;
      logic [7:0] data;
   } rdr_wr_t;

   // two-wire engine states, one-hot
   typedef enum logic [4:0] {
      RDR_ST_IDLE = 5'h01,
      RDR_ST_ADDR = 5'h02,
      RDR_ST_OFFS = 5'h04,
      RDR_ST_WDAT = 5'h08,
      RDR_ST_RDAT = 5'h10
   } rdr_i2c_st_t;

   // register offsets
   localparam logic [7:0] RDR_OFF_LANE_MODE = 8'h09;
   localparam logic [7:0] RDR_OFF_SIG_DETECT_CTRL = 8'h0A;
   localparam logic [7:0] RDR_OFF_TERM = 8'h0B;
   localparam logic [7:0] RDR_OFF_GEQ = 8'h0D;
   localparam logic [7:0] RDR_OFF_STATUS = 8'h20;
   localparam logic [7:0] RDR_OFF_PAIR_A = 8'h4E;
   localparam logic [7:0] RDR_OFF_PAIR_B = 8'h4F;

   // field positions
   localparam int RDR_BIT_LANE_MODE = 6;
   localparam int RDR_BIT_SIGNAL_DETECT_ENABLE = 0;
   localparam int RDR_BIT_RATIO = 1;
   localparam int RDR_BIT_TERM_LO = 3;
   localparam int RDR_BIT_GEQ_LO = 3;
   localparam int RDR_BIT_CLKEQ_LO = 1;
   localparam int RDR_BIT_CLK_VALID = 5;

   // values after reset
   localparam logic [7:0] RDR_RST_LANE_MODE = 8'h00;
   localparam logic [7:0] RDR_RST_SIG_DETECT_CTRL = 8'h01;
   localparam logic [7:0] RDR_RST_TERM = 8'h00;
   localparam logic [7:0] RDR_RST_GEQ = 8'h00;
   localparam logic [7:0] RDR_RST_PAIR = 8'h00;

   // termination encodings, shared by register field and output
   localparam logic [1:0] RDR_TERM_150_300 = 2'h0;
   localparam logic [1:0] RDR_TERM_NONE = 2'h1;
   localparam logic [1:0] RDR_TERM_AUTO = 2'h2;
   localparam logic [1:0] RDR_TERM_75_150 = 2'h3;

   // strap equaliser codes (2, 3, 5, 6.5, 8.5, 10, 11, 14.5, 15.5 dB)
   localparam logic [3:0] RDR_EQ_00 = 4'h0;
   localparam logic [3:0] RDR_EQ_0Z = 4'h1;
   localparam logic [3:0] RDR_EQ_01 = 4'h3;
   localparam logic [3:0] RDR_EQ_Z0 = 4'h4;
   localparam logic [3:0] RDR_EQ_ZZ = 4'h6;
   localparam logic [3:0] RDR_EQ_Z1 = 4'h8;
   localparam logic [3:0] RDR_EQ_10 = 4'h9;
   localparam logic [3:0] RDR_EQ_1Z = 4'hD;
   localparam logic [3:0] RDR_EQ_11 = 4'hF;

   // two-wire addresses (7-bit); host base is arbitrary, low two bits from straps
   localparam logic [6:0] RDR_HOST_ADDR_BASE = 7'h2C;
   localparam logic [6:0] RDR_SNOOP_ADDR = 7'h54;
   localparam logic [7:0] RDR_SNOOP_OFF = 8'h20;
   localparam logic [3:0] RDR_ACK_SLOT = 4'h8;
endpackage

// ==== tb_redriver_eq_term_sigdetect_ctrl.sv ====
// self-checking bench of the equaliser, termination and signal detect control
module tb_redriver_eq_term_sigdetect_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic reg_ctrl_en = 1'b0;
   logic clock_valid = 1'b1;
   rdr_pkg::rdr_strap_pin_t eql = '0, eqh = '0, ts = '0;
   logic hscl, hsda, hoe_n, dscl, dsda, sda_o, stb, hs_hiz, di_hiz;
   rdr_pkg::rdr_lane_eq_t gain;
   logic [1:0] term;
   logic [7:0] rv;
   int failures = 0;
   int cmp_count = 0;
   logic [3:0] eqtab [9] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h6, 4'h8, 4'h9, 4'hD, 4'hF};
   logic [1:0] ttab [3] = '{2'h0, 2'h1, 2'h3}; // low, floating, high
   logic [1:0] ftab [4] = '{2'h0, 2'h1, 2'h1, 2'h3}; // auto reads none with flag clear
   initial forever #4 clk = ~clk;
   rdr_eq_term_ctrl i_dut (.clk(clk), .nrst(nrst), .reg_ctrl_en(reg_ctrl_en), .equalizer_strap_low(eql),
      .equalizer_strap_high(eqh), .term_strap(ts), .clock_valid(clock_valid), .host_scl(hscl),
      .host_sda_in(hsda), .host_sda_out(sda_o), .host_sda_oe_n(hoe_n), .ddc_scl(dscl), .ddc_sda_in(dsda),
      .receive_gain(gain), .term_sel(term), .standby(stb), .hs_out_hiz(hs_hiz), .data_in_hiz(di_hiz));
   rdr_host_model i_host (.clk(clk), .dev_oe_n(hoe_n), .scl(hscl), .sda(hsda));
   // snoop link: the device only listens, so nothing else pulls the line
   rdr_host_model i_src (.clk(clk), .dev_oe_n(1'b1), .scl(dscl), .sda(dsda));
   function automatic rdr_pkg::rdr_strap_pin_t mk(input int l);
      mk.pulled_high = (l == 2);
      mk.floating = (l == 1);
   endfunction
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("FAIL %s expected %h seen %h", n, e, g);
         failures++;
      end
   endtask
   // straps are only taken on the first edge after release
   task automatic do_reset();
      nrst = 1'b0;
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
   endtask
   task automatic finish_test();
      if (failures == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (100000) @(posedge clk);
      failures++;
      finish_test();
   end
   initial begin
      for (int i = 0; i < 9; i++) begin
         eqh = mk(i / 3);
         eql = mk(i % 3);
         ts = mk(i % 3);
         do_reset();
         chk("strap gain", {4{eqtab[i]}}, gain);
         chk("strap term", {14'h0, ttab[i % 3]}, {14'h0, term});
      end
      eqh = mk(0);
      eql = mk(0);
      ts = mk(0);
      do_reset();
      clock_valid = 1'b0;
      repeat (3) @(negedge clk);
      chk("standby", 16'h0007, {13'h0, stb, hs_hiz, di_hiz});
      i_host.rd(7'h2C, 8'h20, rv);
      chk("status lost", 16'h0000, {8'h0, rv});
      clock_valid = 1'b1;
      repeat (3) @(negedge clk);
      chk("active", 16'h0000, {13'h0, stb, hs_hiz, di_hiz});
      i_host.rd(7'h2C, 8'h20, rv);
      chk("status ok", 16'h0020, {8'h0, rv});
      reg_ctrl_en = 1'b1;
      i_host.wr(7'h2C, 8'h0D, 8'h7C);
      chk("host ack", 16'h0001, {14'h0, sda_o, i_host.k});
      chk("global gain", 16'h8FFF, gain);
      i_host.rd(7'h2C, 8'h0D, rv);
      chk("geq readback", 16'h007C, {8'h0, rv});
      i_host.rd(7'h2C, 8'h30, rv);
      chk("unmapped", 16'h0000, {8'h0, rv});
      i_host.wr(7'h2C, 8'h09, 8'h40);
      i_host.wr(7'h2C, 8'h4E, 8'h21);
      i_host.wr(7'h2C, 8'h4F, 8'h03);
      chk("lane gain", 16'h8123, gain);
      for (int v = 0; v < 4; v++) begin
         i_host.wr(7'h2C, 8'h0B, 8'(v << 3));
         chk("term field", {14'h0, ftab[v]}, {14'h0, term});
      end
      i_host.wr(7'h2C, 8'h0B, 8'h0A);
      chk("ratio forces", 16'h0003, {14'h0, term});
      i_host.wr(7'h2C, 8'h0B, 8'h10);
      i_src.wr(7'h54, 8'h20, 8'h02);
      chk("snoop set", 16'h0003, {14'h0, term});
      i_src.wr(7'h54, 8'h20, 8'h00);
      chk("snoop clear", 16'h0001, {14'h0, term});
      reg_ctrl_en = 1'b0;
      repeat (3) @(negedge clk);
      chk("back to strap", 16'h0000, {14'h0, term});
      finish_test();
   end
endmodule // tb_redriver_eq_term_sigdetect_ctrl
